// ===== cmpss_pkg.sv
// Constants and types for the current-mode pulse generator
`default_nettype none

package cmpss_pkg;

    // System clock
    localparam int CLK_HZ = 10_000_000;
    localparam int CLK_NS = 100;

    // Oscillator, duty limit and jitter
    localparam int OSC_HZ = 100_000;
    localparam int OSC_PER_CYC = CLK_HZ / OSC_HZ;
    localparam int JIT_DEV_HZ = 4_000;
    localparam int JIT_DEV_CYC = OSC_PER_CYC * JIT_DEV_HZ / OSC_HZ;
    localparam int OSC_PER_MIN = OSC_PER_CYC - JIT_DEV_CYC;
    localparam int JIT_PER_MS = 4;
    localparam int JIT_PER_CYC = JIT_PER_MS * 1_000_000 / CLK_NS;
    localparam int DMAX_NUM = 3;
    localparam int DMAX_SHIFT = 2;

    // Turn-on hold-off and blanking, least times rounded up
    localparam int HOLD_NS = 156;
    localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int BLANK_NORM_NS = 220;
    localparam int BLANK_NORM_CYC = (BLANK_NORM_NS + CLK_NS - 1) / CLK_NS;
    localparam int BLANK_BURST_NS = 180;
    localparam int BLANK_BURST_CYC = (BLANK_BURST_NS + CLK_NS - 1) / CLK_NS;

    // Soft start
    localparam int SS_STEPS = 32;
    localparam int SS_STEP_US = 300;
    localparam int SS_STEP_CYC = SS_STEP_US * 1_000 / CLK_NS;
    localparam int SS_END_MS = 10;
    localparam int SS_END_CYC = SS_END_MS * 1_000_000 / CLK_NS;
    localparam logic [11:0] SS_LEVEL_STEP = 12'h07f;

    // Sense path: gain 3.25 is 13 / 4
    localparam int GAIN_NUM = 13;
    localparam int GAIN_SHIFT = 2;
    localparam int RAMP_SHIFT = 2;
    localparam logic [9:0] PEAK_TH = 10'h200;
    localparam logic [9:0] BURST_TH = 10'h0c0;

    // Values after reset
    localparam logic [1:0] BLANK_CNT_RST = 2'h3;

    // Sampled sense voltage and feedback level
    typedef struct packed {
        logic [9:0] sense;
        logic [11:0] feedback;
    } cmpss_analog_type;

    // Soft-start sequencer
    typedef enum logic [1:0] {
        SS_IDLE = 2'b00,
        SS_RAMP = 2'b01,
        SS_DONE = 2'b10
    } cmpss_ss_state_type;

endpackage : cmpss_pkg

`default_nettype wire

// ===== cmpss_power_stage.sv
// Model of the power switch, shunt and feedback opto
`default_nettype none

module cmpss_power_stage (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Gate command from the controller
    input wire logic gate,
    // Scenario controls
    input wire logic [9:0] sense_level,
    input wire logic [11:0] feedback_level,
    // Sensed values back to the controller
    output var cmpss_pkg::cmpss_analog_type analog
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [9:0] sense;

    // Shunt shows current only while the switch conducts
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sense <= 10'h000;
        end else begin
            sense <= gate ? sense_level : 10'h000;
        end
    end

    // Opto level follows the control, no added delay
    assign analog = {sense, feedback_level};

endmodule : cmpss_power_stage

`default_nettype wire

// ===== cmpss_top.sv
// Current-mode pulse generator with soft start, jitter and blanking
`default_nettype none

module cmpss_top #(
    parameter int SS_END_CYC = cmpss_pkg::SS_END_CYC,
    parameter int JIT_PER_CYC = cmpss_pkg::JIT_PER_CYC
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // Supply monitor comparators
    input wire logic SUPPLY_ON_HIT,
    input wire logic SUPPLY_OFF_HIT,
    // Control unit requests
    input wire logic RESTART_ATTEMPT,
    input wire logic BURST_MODE,
    // Sampled sense voltage and feedback level
    input wire cmpss_pkg::cmpss_analog_type ANALOG_IN,
    // Gate driver and status
    output logic GATE_DRIVE,
    output logic BIAS_ON,
    output logic SOFTSTART_DONE,
    output logic RAMP_HOLD,
    output logic [11:0] SOFTSTART_LEVEL
);

    localparam int JIT_STEP_CYC = JIT_PER_CYC / (4 * cmpss_pkg::JIT_DEV_CYC);
    localparam logic [4:0] SS_LAST = 5'(cmpss_pkg::SS_STEPS - 1);

    logic bias;
    cmpss_pkg::cmpss_ss_state_type ss_state;
    cmpss_pkg::cmpss_ss_state_type next_ss_state;
    logic [4:0] ss_step;
    logic [11:0] ss_tick;
    logic [16:0] ss_time;
    logic [11:0] ss_level;
    logic [15:0] jit_cnt;
    logic [3:0] jit_phase;
    logic [6:0] osc_cnt;
    logic [6:0] period;
    logic pulse_latch;
    logic [1:0] blank_cnt;
    logic blank_burst;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    // Supply monitor: off-level wins over on-level
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            bias <= 1'b0;
        end else if (SUPPLY_OFF_HIT) begin
            bias <= 1'b0;
        end else if (SUPPLY_ON_HIT) begin
            bias <= 1'b1;
        end
    end

    // Soft-start decode
    wire ss_clear = !bias || SUPPLY_OFF_HIT || RESTART_ATTEMPT;
    wire ss_running = (ss_state == cmpss_pkg::SS_RAMP);
    wire ss_done = (ss_state == cmpss_pkg::SS_DONE);
    wire step_wrap = ss_running &&
        (ss_tick == 12'(cmpss_pkg::SS_STEP_CYC - 1));
    wire time_end = ss_running && (ss_time == 17'(SS_END_CYC - 1));

    // Soft-start sequencer next state
    always_comb begin
        next_ss_state = ss_state;
        unique case (ss_state)
            cmpss_pkg::SS_IDLE: begin
                if (!ss_clear) begin
                    next_ss_state = cmpss_pkg::SS_RAMP;
                end
            end
            cmpss_pkg::SS_RAMP: begin
                if (ss_clear) begin
                    next_ss_state = cmpss_pkg::SS_IDLE;
                end else if (time_end) begin
                    next_ss_state = cmpss_pkg::SS_DONE;
                end
            end
            cmpss_pkg::SS_DONE: begin
                if (ss_clear) begin
                    next_ss_state = cmpss_pkg::SS_IDLE;
                end
            end
            default: begin
                next_ss_state = cmpss_pkg::SS_IDLE;
            end
        endcase
    end

    // Soft-start state register
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ss_state <= cmpss_pkg::SS_IDLE;
        end else begin
            ss_state <= next_ss_state;
        end
    end

    // Step interval and total soft-start timers
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ss_tick <= 12'h000;
            ss_time <= 17'h00000;
        end else if (ss_clear || !ss_running) begin
            ss_tick <= 12'h000;
            ss_time <= 17'h00000;
        end else begin
            ss_tick <= step_wrap ? 12'h000 : ss_tick + 12'h001;
            ss_time <= ss_time + 17'h00001;
        end
    end

    // Step counter and limit level, cleared to the first step
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ss_step <= 5'h00;
            ss_level <= cmpss_pkg::SS_LEVEL_STEP;
        end else if (ss_clear) begin
            ss_step <= 5'h00;
            ss_level <= cmpss_pkg::SS_LEVEL_STEP;
        end else if (step_wrap && ss_step != SS_LAST) begin
            ss_step <= ss_step + 5'h01;
            ss_level <= ss_level + cmpss_pkg::SS_LEVEL_STEP;
        end
    end

    // Jitter triangle, frozen at its start until soft start ends
    wire jit_wrap = (jit_cnt == 16'(JIT_STEP_CYC - 1));
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            jit_cnt <= 16'h0000;
            jit_phase <= 4'h0;
        end else if (!ss_done) begin
            jit_cnt <= 16'h0000;
            jit_phase <= 4'h0;
        end else if (jit_wrap) begin
            jit_cnt <= 16'h0000;
            jit_phase <= jit_phase + 4'h1;
        end else begin
            jit_cnt <= jit_cnt + 16'h0001;
        end
    end

    // Period select: 96 to 104 cycles with jitter, else 100
    wire [3:0] jit_idx = (jit_phase <= 4'h8) ? jit_phase :
        4'(5'h10 - {1'b0, jit_phase});
    wire [6:0] next_period = ss_done ?
        7'(cmpss_pkg::OSC_PER_MIN) + {3'h0, jit_idx} :
        7'(cmpss_pkg::OSC_PER_CYC);

    // Oscillator counter, new period taken at each wrap
    wire osc_wrap = (osc_cnt == period - 7'h01);
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            osc_cnt <= 7'h00;
            period <= 7'(cmpss_pkg::OSC_PER_CYC);
        end else if (osc_wrap) begin
            osc_cnt <= 7'h00;
            period <= next_period;
        end else begin
            osc_cnt <= osc_cnt + 7'h01;
        end
    end

    // Duty window, ramp and set instant
    wire [6:0] on_max = 7'((9'(period) * 9'(cmpss_pkg::DMAX_NUM))
        >> cmpss_pkg::DMAX_SHIFT);
    wire osc_on = (osc_cnt < on_max);
    wire set_evt = (osc_cnt == 7'(cmpss_pkg::HOLD_CYC));
    wire [12:0] ramp = osc_on ?
        13'({6'h00, osc_cnt} << cmpss_pkg::RAMP_SHIFT) : 13'h0000;

    // Blanking counter restarted at every set instant
    wire [1:0] blank_len = blank_burst ?
        2'(cmpss_pkg::BLANK_BURST_CYC) :
        2'(cmpss_pkg::BLANK_NORM_CYC);
    wire blank_active = (blank_cnt < blank_len);
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            blank_cnt <= cmpss_pkg::BLANK_CNT_RST;
            blank_burst <= 1'b0;
        end else if (set_evt) begin
            blank_cnt <= 2'h0;
            blank_burst <= BURST_MODE;
        end else if (blank_active) begin
            blank_cnt <= blank_cnt + 2'h1;
        end
    end

    // Blanked sense path and amplifier
    wire sense_ok = pulse_latch && !blank_active;
    wire [9:0] sense_eff = sense_ok ? ANALOG_IN.sense : 10'h000;
    // Product kept wide so a full-scale sense code cannot wrap
    wire [12:0] amp = 13'((15'(sense_eff) *
        15'(cmpss_pkg::GAIN_NUM)) >> cmpss_pkg::GAIN_SHIFT);
    wire [12:0] comp = amp + ramp;

    // Reset sources of the pulse latch
    wire duty_trip = (comp > {1'b0, ANALOG_IN.feedback});
    wire ss_trip = !ss_done && (ss_step != SS_LAST) &&
        (comp > {1'b0, ss_level});
    wire peak_trip = sense_ok &&
        (ANALOG_IN.sense > cmpss_pkg::PEAK_TH);
    wire burst_trip = sense_ok && BURST_MODE &&
        (ANALOG_IN.sense > cmpss_pkg::BURST_TH);
    wire latch_reset = duty_trip || ss_trip || peak_trip ||
        burst_trip || !osc_on || !bias;

    // Pulse latch, reset has priority over set
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pulse_latch <= 1'b0;
        end else if (latch_reset) begin
            pulse_latch <= 1'b0;
        end else if (set_evt) begin
            pulse_latch <= 1'b1;
        end
    end

    // Outputs; gate drops in the same cycle as any reset
    assign GATE_DRIVE = pulse_latch && !latch_reset;
    assign BIAS_ON = bias;
    assign SOFTSTART_DONE = ss_done;
    assign RAMP_HOLD = !osc_on;
    assign SOFTSTART_LEVEL = ss_level;

    // Latch is set after a clean set instant
    property p_latch_set;
        set_evt && !latch_reset |=> pulse_latch;
    endproperty
    a_latch_set: assert property (p_latch_set)
        else $error("latch not set by oscillator");

    // Ramp at start and gate low outside duty window
    property p_off_window;
        !osc_on |-> (ramp == 13'h0000) && !GATE_DRIVE;
    endproperty
    a_off_window: assert property (p_off_window)
        else $error("gate or ramp active in off interval");

    // No gate before hold-off expires
    property p_hold_off;
        osc_cnt <= 7'(cmpss_pkg::HOLD_CYC) |-> !GATE_DRIVE;
    endproperty
    a_hold_off: assert property (p_hold_off)
        else $error("gate on during hold-off");

    // Rising bias starts the sequence
    property p_ss_start;
        $rose(BIAS_ON) && !RESTART_ATTEMPT && !SUPPLY_OFF_HIT
            |=> ss_state == cmpss_pkg::SS_RAMP && ss_step == 5'h00;
    endproperty
    a_ss_start: assert property (p_ss_start)
        else $error("soft start not begun at turn-on");

    // Step advance at each interval
    property p_ss_step;
        step_wrap && !ss_clear && ss_step != SS_LAST
            |=> ss_step == $past(ss_step) + 5'h01;
    endproperty
    a_ss_step: assert property (p_ss_step)
        else $error("soft-start step did not advance");

    // Sequence end and limit release
    property p_ss_end;
        time_end && !ss_clear |=> SOFTSTART_DONE && !ss_trip;
    endproperty
    a_ss_end: assert property (p_ss_end)
        else $error("soft start did not end on time");

    // Restart clears the sequence
    property p_restart;
        RESTART_ATTEMPT |=> ss_step == 5'h00 && !SOFTSTART_DONE;
    endproperty
    a_restart: assert property (p_restart)
        else $error("restart did not clear soft start");

    // Nominal period without jitter
    property p_nominal;
        osc_wrap && !ss_done |=> period == 7'(cmpss_pkg::OSC_PER_CYC);
    endproperty
    a_nominal: assert property (p_nominal)
        else $error("period jittered during soft start");

    // Jitter stays within its deviation
    property p_jit_range;
        period >= 7'(cmpss_pkg::OSC_PER_MIN) &&
        period <= 7'(cmpss_pkg::OSC_PER_MIN + 2 * cmpss_pkg::JIT_DEV_CYC);
    endproperty
    a_jit_range: assert property (p_jit_range)
        else $error("period outside jitter range");

    // Undervoltage clears bias and soft start
    property p_uvlo;
        SUPPLY_OFF_HIT |=> !BIAS_ON && !GATE_DRIVE && ss_step == 5'h00;
    endproperty
    a_uvlo: assert property (p_uvlo)
        else $error("undervoltage did not shut down");

    // Peak or burst trip drops the gate at once
    property p_trip;
        peak_trip || burst_trip |-> !GATE_DRIVE ##1 !pulse_latch;
    endproperty
    a_trip: assert property (p_trip)
        else $error("current limit did not end on-time");

    // Blanking length after each set instant
    property p_blank_norm;
        set_evt && !BURST_MODE |=> blank_active [*3] ##1 !blank_active;
    endproperty
    a_blank_norm: assert property (p_blank_norm)
        else $error("normal blanking length wrong");

    property p_blank_burst;
        set_evt && BURST_MODE |=> blank_active [*2] ##1 !blank_active;
    endproperty
    a_blank_burst: assert property (p_blank_burst)
        else $error("burst blanking length wrong");

    // Main scenarios
    c_gate_pulse: cover property ($rose(GATE_DRIVE));
    c_ss_done: cover property ($rose(SOFTSTART_DONE));
    c_peak: cover property (peak_trip && pulse_latch);
    c_burst: cover property (burst_trip && !peak_trip);

endmodule : cmpss_top

`default_nettype wire

// ===== test_cmpss_top.sv
// Self-checking bench for the current-mode pulse generator
`default_nettype none

module test_cmpss_top;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int SS_END = 7000;
    localparam int JIT_PER = 16000;

    logic SYS_CLK, RST_N, SUPPLY_ON_HIT, SUPPLY_OFF_HIT;
    logic RESTART_ATTEMPT, BURST_MODE, GATE_DRIVE, BIAS_ON;
    logic SOFTSTART_DONE, RAMP_HOLD, rh;
    logic [11:0] SOFTSTART_LEVEL, fb;
    logic [9:0] sl;
    cmpss_pkg::cmpss_analog_type ANALOG_IN;
    logic [31:0] seed = 32'h59d5126c;
    int mismatches = 0;
    int checked = 0;
    int cyc = 0, hw = 0, highs = 0, per = 0, trise = 0;
    int note[$];
    logic gprev = 1'b0;
    event fell, rose;
    logic [11:0] fbt[4] = '{12'h03f, 12'h12c, 12'hfff, 12'hfff};
    logic [9:0] slt[4] = '{10'h000, 10'h040, 10'h201, 10'h0c1};
    logic bmt[4] = '{1'b0, 1'b0, 1'b0, 1'b1};
    int wt[4] = '{13, 21, 3, 2};

    cmpss_top #(.SS_END_CYC(SS_END), .JIT_PER_CYC(JIT_PER)) u_cmpss_top (
        .SYS_CLK(SYS_CLK), .RST_N(RST_N), .SUPPLY_ON_HIT(SUPPLY_ON_HIT),
        .SUPPLY_OFF_HIT(SUPPLY_OFF_HIT), .RESTART_ATTEMPT(RESTART_ATTEMPT),
        .BURST_MODE(BURST_MODE), .ANALOG_IN(ANALOG_IN),
        .GATE_DRIVE(GATE_DRIVE), .BIAS_ON(BIAS_ON),
        .SOFTSTART_DONE(SOFTSTART_DONE), .RAMP_HOLD(RAMP_HOLD),
        .SOFTSTART_LEVEL(SOFTSTART_LEVEL));

    cmpss_power_stage u_cmpss_power_stage (.clk(SYS_CLK), .rst_n(RST_N),
        .gate(GATE_DRIVE), .sense_level(sl), .feedback_level(fb),
        .analog(ANALOG_IN));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h00000000);
    endfunction : lfsr

    task automatic tick(input int n);
        repeat (n) @(posedge SYS_CLK);
    endtask : tick

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk

    task automatic chk_width(input string nm, input int e, input int g);
        checked++;
        if (g != e) begin
            mismatches++;
            $display("[ERR] %s expected %0d seen %0d", nm, e, g);
        end
    endtask : chk_width

    // Note the width of the pulse after the next one that ends
    task automatic expect_w(input int w);
        @(fell);
        note.push_back(w);
        @(fell);
    endtask : expect_w

    // Wait for a soft-start level and check when it came
    task automatic wait_level(input logic [11:0] v, input int t0,
                              input int e);
        int d;
        while (SOFTSTART_LEVEL !== v && cyc - t0 < e + 100) begin
            @(negedge SYS_CLK);
        end
        d = cyc - t0 - e;
        chk("level", v, SOFTSTART_LEVEL);
        chk_width("step time", 1, int'(d >= -5 && d <= 5));
    endtask : wait_level

    task automatic final_report;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    // Clock
    initial begin
        SYS_CLK = 1'b0;
        forever #50 SYS_CLK = ~SYS_CLK;
    end

    // Watchdog well beyond the planned run length
    initial begin
        tick(60000);
        mismatches++;
        final_report();
    end

    // Result watcher: gate widths and periods between edges
    always @(negedge SYS_CLK) begin
        cyc++;
        if (GATE_DRIVE === 1'b1) begin
            hw++;
            highs++;
            if (!gprev) begin
                per = cyc - trise;
                trise = cyc;
                ->rose;
            end
        end else if (gprev) begin
            rh = RAMP_HOLD;
            if (note.size() > 0) begin
                chk_width("gate width", note.pop_front(), hw);
            end
            hw = 0;
            ->fell;
        end
        gprev = (GATE_DRIVE === 1'b1);
    end

    // Main sequence
    initial begin
        int t, mn, mx, h;
        RST_N = 1'b0;
        SUPPLY_ON_HIT = 1'b0;
        SUPPLY_OFF_HIT = 1'b0;
        RESTART_ATTEMPT = 1'b0;
        BURST_MODE = 1'b0;
        fb = 12'hfff;
        sl = 10'h000;
        tick(12);
        chk("gate", 1'b0, GATE_DRIVE);
        chk("bias", 1'b0, BIAS_ON);
        chk("done", 1'b0, SOFTSTART_DONE);
        chk("hold", 1'b0, RAMP_HOLD);
        chk("level", 12'h07f, SOFTSTART_LEVEL);
        RST_N <= 1'b1;
        tick(300);
        chk_width("pulses off", 0, highs);
        $display("test reset ended");
        SUPPLY_ON_HIT <= 1'b1;
        @(negedge SYS_CLK);
        chk("bias early", 1'b0, BIAS_ON);
        @(negedge SYS_CLK);
        t = cyc;
        chk("bias on", 1'b1, BIAS_ON);
        expect_w(29);
        @(rose);
        chk_width("period", 100, per);
        wait_level(12'h0fe, t, 3000);
        expect_w(61);
        wait_level(12'h17d, t, 6000);
        expect_w(72);
        chk("hold at limit", 1'b1, rh);
        while (SOFTSTART_DONE !== 1'b1 && cyc - t < SS_END + 100) begin
            @(negedge SYS_CLK);
        end
        h = cyc - t - SS_END;
        chk_width("done time", 1, int'(h >= -5 && h <= 5));
        @(fell);
        expect_w(69);
        $display("test soft start ended");
        mn = 1000;
        mx = 0;
        repeat (170) begin
            @(rose);
            mn = (per < mn) ? per : mn;
            mx = (per > mx) ? per : mx;
            seed = lfsr(seed);
            @(posedge SYS_CLK);
            fb <= {2'b11, seed[9:0]};
        end
        chk_width("min period", 96, mn);
        chk_width("max period", 104, mx);
        $display("test jitter ended");
        for (int i = 0; i < 4; i++) begin
            @(posedge SYS_CLK);
            fb <= fbt[i];
            sl <= slt[i];
            BURST_MODE <= bmt[i];
            expect_w(wt[i]);
        end
        @(posedge SYS_CLK);
        fb <= 12'h000;
        sl <= 10'h000;
        BURST_MODE <= 1'b0;
        tick(100);
        h = highs;
        tick(300);
        chk_width("zero duty", 0, highs - h);
        $display("test sense paths ended");
        fb <= 12'hfff;
        RESTART_ATTEMPT <= 1'b1;
        tick(1);
        RESTART_ATTEMPT <= 1'b0;
        tick(2);
        @(negedge SYS_CLK);
        chk("restart done", 1'b0, SOFTSTART_DONE);
        chk("restart level", 12'h07f, SOFTSTART_LEVEL);
        expect_w(29);
        $display("test restart ended");
        @(posedge SYS_CLK);
        SUPPLY_OFF_HIT <= 1'b1;
        tick(2);
        @(negedge SYS_CLK);
        chk("bias off", 1'b0, BIAS_ON);
        h = highs;
        tick(300);
        chk_width("pulses low", 0, highs - h);
        chk("level off", 12'h07f, SOFTSTART_LEVEL);
        $display("test undervoltage ended");
        final_report();
    end

endmodule : test_cmpss_top

`default_nettype wire
